// ---- include/host_port_pkg.sv ----
// Purpose: Shared constants and types for the parallel host register port.
// Assumes: One 40 MHz system clock; host pins are asynchronous to it.
// Notes:   The register array itself lives in the top module.
`default_nettype none
package host_port_pkg;

  // ****************************************
  // Bus styles
  // ****************************************
  localparam logic [2:0] STYLE_STROBE = 3'h0;
  localparam logic [2:0] STYLE_ALT    = 3'h1;
  localparam logic [2:0] STYLE_SYNC   = 3'h7;

  // ****************************************
  // Address and data layout
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CSEL_W = 3;
  localparam int REG_COUNT = 256;
  localparam int STATUS_W = 8;
  localparam logic [CSEL_W-1:0] CSEL_SELF = 3'h0;
  localparam logic [CSEL_W-1:0] CSEL_ALL  = 3'h7;
  localparam logic [CSEL_W-1:0] CSEL_RSVD = 3'h6;
  localparam logic [7:0] STATUS_BASE = 8'hf0;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int DONE_MAX_NS = 90;
  // Longest strobe-to-done time, rounded down to whole cycles
  localparam int DONE_MAX_CYC = DONE_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic sel_n;
    logic strobe_a_n;
    logic strobe_b_n;
    logic addr_latch;
    logic host_clk;
  } host_ctl_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   The first stage is read only by the second.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Pins
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/edge_detect.sv ----
// Purpose: Rising and falling edge pulses on a synchronised level.
// Assumes: Input is already in the system clock domain.
// Notes:   Pulses last one cycle.
`default_nettype none
module edge_detect #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Level and pulses
  input wire logic i_level,
  output logic o_rise,
  output logic o_fall
);
  logic last_q;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_q <= INIT;
    end else begin
      last_q <= i_level;
    end
  end

  assign o_rise = i_level & ~last_q;
  assign o_fall = ~i_level & last_q;
endmodule
`default_nettype wire

// ---- rtl/host_register_port.sv ----
// Purpose: Parallel host port to the on-chip configuration and status registers.
// Assumes: Host pins are asynchronous and pass two flip-flops before use.
// Notes:   Status registers at the top of the map are read-only device state.
`default_nettype none
module host_register_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Straps
  input wire logic [2:0] i_bus_style_select,
  // Host control pins
  input wire logic i_sel_n,
  input wire logic i_addr_latch_strobe,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_host_clk,
  // Host address and data
  input wire logic [CSEL_W+ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_cycle_done_n,
  // Device side
  input wire logic [STATUS_W-1:0] i_status,
  input wire logic i_event,
  output logic [DATA_W-1:0] o_cfg0,
  output logic o_irq_n,
  output logic o_style_bad
);

  // ****************************************
  // Synchronisers
  // ****************************************
  host_ctl_t ctl_raw;
  host_ctl_t ctl_s;
  logic [CSEL_W+ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [2:0] style_s;

  assign ctl_raw = '{sel_n: i_sel_n, strobe_a_n: i_rd_n, strobe_b_n: i_wr_n,
                     addr_latch: i_addr_latch_strobe, host_clk: i_host_clk};

  pin_sync #(.WIDTH(5)) u_sync_ctl (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(ctl_raw),
    .o_sync(ctl_s)
  );

  pin_sync #(.WIDTH(CSEL_W+ADDR_W+DATA_W+3)) u_sync_bus (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async({i_addr, i_data, i_bus_style_select}),
    .o_sync({addr_s, data_s, style_s})
  );

  // ****************************************
  // Edges
  // ****************************************
  logic ale_rise, ale_fall;
  logic a_rise, a_fall, b_rise, b_fall;
  logic hclk_rise, hclk_fall;

  edge_detect #(.INIT(1'b0)) u_ed_ale (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_level(ctl_s.addr_latch), .o_rise(ale_rise), .o_fall(ale_fall)
  );
  edge_detect #(.INIT(1'b0)) u_ed_a (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_level(ctl_s.strobe_a_n), .o_rise(a_rise), .o_fall(a_fall)
  );
  edge_detect #(.INIT(1'b0)) u_ed_b (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_level(ctl_s.strobe_b_n), .o_rise(b_rise), .o_fall(b_fall)
  );
  edge_detect #(.INIT(1'b0)) u_ed_hclk (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_level(ctl_s.host_clk), .o_rise(hclk_rise), .o_fall(hclk_fall)
  );

  // ****************************************
  // Style decode
  // ****************************************
  logic style_sync, style_async, style_ok;
  assign style_sync = (style_s == STYLE_SYNC);
  assign style_async = (style_s == STYLE_STROBE) || (style_s == STYLE_ALT);
  assign style_ok = style_sync | style_async;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_style_bad <= 1'b0;
    end else begin
      o_style_bad <= ~style_ok;
    end
  end

  // ****************************************
  // Address latch
  // ****************************************
  logic [ADDR_W-1:0] addr_lat_q;
  logic [ADDR_W-1:0] addr_eff;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_lat_q <= '0;
    end else if (ale_fall) begin
      addr_lat_q <= addr_s[ADDR_W-1:0];
    end
  end

  assign addr_eff = ctl_s.addr_latch ? addr_s[ADDR_W-1:0] : addr_lat_q;

  // Chip-select decode; reserved code selects nobody
  logic chip_hit;
  assign chip_hit = (addr_s[CSEL_W+ADDR_W-1:ADDR_W] == CSEL_SELF) ||
                    (addr_s[CSEL_W+ADDR_W-1:ADDR_W] == CSEL_ALL);

  logic selected;
  assign selected = ~ctl_s.sel_n & chip_hit & style_ok;

  // ****************************************
  // Request decode
  // ****************************************
  logic start_rd, start_wr, strobe_end;
  always_comb begin
    start_rd = 1'b0;
    start_wr = 1'b0;
    strobe_end = 1'b0;
    if (style_async) begin
      start_rd = selected & a_fall;
      start_wr = selected & b_fall;
      strobe_end = a_rise | b_rise;
    end else if (style_sync) begin
      // Direction on second strobe pin, start on first
      start_rd = selected & a_fall & ctl_s.strobe_b_n;
      start_wr = selected & a_fall & ~ctl_s.strobe_b_n;
      strobe_end = a_rise;
    end
  end

  // ****************************************
  // Cycle state machine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } cyc_state_t;

  cyc_state_t state_q;
  logic rd_cycle_q;
  logic release_cond;
  // End of strobe or loss of select
  assign release_cond = strobe_end | ctl_s.sel_n;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_rd | start_wr) begin
            state_q <= style_sync ? ST_WAIT : ST_DONE;
          end
        end
        ST_WAIT: begin
          // Done paced by the host clock
          if (ctl_s.sel_n) begin
            state_q <= ST_IDLE;
          end else if (hclk_rise) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (release_cond) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_cycle_q <= 1'b0;
    end else if (start_rd | start_wr) begin
      rd_cycle_q <= start_rd;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cycle_done_n <= 1'b1;
    end else begin
      o_cycle_done_n <= ~((state_q == ST_DONE) & ~release_cond);
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [DATA_W-1:0] regs_q [REG_COUNT];
  reg_req_t req;
  assign req = '{write: start_wr, addr: addr_eff, wdata: data_s};

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (req.write && req.addr < STATUS_BASE) begin
      regs_q[req.addr] <= req.wdata;
    end
  end

  assign o_cfg0 = regs_q[0];

  logic [DATA_W-1:0] rd_word;
  assign rd_word = (addr_eff >= STATUS_BASE) ? i_status : regs_q[addr_eff];

  // Data driven out only during reads
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= '0;
      o_data_oe_n <= 1'b1;
    end else begin
      if (start_rd) begin
        o_data <= rd_word;
      end
      o_data_oe_n <= ~(rd_cycle_q & (state_q != ST_IDLE) & ~release_cond) & ~start_rd;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= ~i_event;
    end
  end

endmodule
`default_nettype wire

// ---- bench/host_register_port_asserts.sv ----
// Purpose: Port-level checks for the host register port.
// Assumes: Host holds select and upper address steady through a cycle.
// Notes:   Latency windows are loose; exact data checks sit in the bench.
`default_nettype none
module host_register_port_asserts
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Host pins
  input wire logic [2:0] i_bus_style_select,
  input wire logic i_sel_n,
  input wire logic i_addr_latch_strobe,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_host_clk,
  input wire logic [CSEL_W+ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic o_cycle_done_n,
  // Device side
  input wire logic [STATUS_W-1:0] i_status,
  input wire logic i_event,
  input wire logic [DATA_W-1:0] o_cfg0,
  input wire logic o_irq_n,
  input wire logic o_style_bad
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire logic async_st = (i_bus_style_select == STYLE_STROBE) || (i_bus_style_select == STYLE_ALT);
  wire logic sync_st = i_bus_style_select == STYLE_SYNC;
  wire logic hit = (i_addr[10:8] == CSEL_SELF) || (i_addr[10:8] == CSEL_ALL);

  // ****
  // Assertions
  // ****
  AST_STYLE_FLAG: assert property (
    $stable(i_bus_style_select) [*4] |-> o_style_bad == !(async_st || sync_st))
    else $error("strap decode flag wrong");
  AST_BAD_QUIET: assert property (
    o_style_bad |-> o_cycle_done_n) else $error("done under bad strap");
  AST_SEL_GATES: assert property (
    i_sel_n [*6] |-> o_cycle_done_n) else $error("done without select");
  AST_CSEL_MISS: assert property (
    $fell(o_cycle_done_n) |-> $past(hit, 4)) else $error("done for other chip");
  AST_WR_DONE: assert property (
    async_st && hit && !i_sel_n && $fell(i_wr_n) |-> ##[2:6] !o_cycle_done_n)
    else $error("write not completed");
  AST_RD_DONE: assert property (
    async_st && hit && !i_sel_n && $fell(i_rd_n)
    |-> ##[2:6] (!o_cycle_done_n && !o_data_oe_n)) else $error("read not completed");
  AST_SYNC_DONE: assert property (
    sync_st && hit && !i_sel_n && $fell(i_rd_n) |-> ##[2:12] !o_cycle_done_n)
    else $error("sync transfer not acknowledged");
  AST_RELEASE: assert property (
    !o_cycle_done_n && ($rose(i_rd_n) || $rose(i_sel_n) || (async_st && $rose(i_wr_n)))
    |-> ##[1:4] o_cycle_done_n) else $error("done not released");
  AST_NO_OE_WRITE: assert property (
    (async_st && !i_wr_n) [*4] |-> o_data_oe_n) else $error("data driven on write");
  AST_IRQ: assert property (
    $stable(i_event) [*4] |-> o_irq_n == !i_event) else $error("event output wrong");

  cover property ($fell(o_cycle_done_n) && !o_data_oe_n);
  cover property ($fell(o_cycle_done_n) && sync_st);
  cover property (o_style_bad);
endmodule

bind host_register_port host_register_port_asserts u_chk (.*);
`default_nettype wire

// ---- bench/host_bus_model.sv ----
// Purpose: Local processor bus model driving the host pins.
// Assumes: Pins change only just after a system clock edge.
// Notes:   Host clock runs only while a transfer is under way.
`default_nettype none
module host_bus_model (
  // Clock and style
  input wire logic i_clk_sys,
  input wire logic i_sync_style,
  // Device answers
  input wire logic i_done_n,
  input wire logic [7:0] i_rdata,
  // Host pins
  output logic o_sel_n,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_hclk,
  output logic [10:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q = 1'b0;

  initial begin
    // Idle bus: select and both strobes high, latch strobe and host clock low
    {o_sel_n, o_ale, o_rd_n, o_wr_n, o_hclk} = 5'h16;
    o_addr = 11'h000;
    o_wdata = 8'h00;
  end

  always @(posedge i_clk_sys) o_hclk <= busy_q & ~o_hclk;

  task automatic xfer(input logic wr, input logic [10:0] a, input logic [7:0] d,
                      input logic ale_hi, output logic [7:0] q, output logic ok);
    int n;
    @(posedge i_clk_sys);
    busy_q <= 1'b1;
    o_addr <= a;
    o_sel_n <= 1'b0;
    o_ale <= 1'b1;
    // Released data line shows inverse, not stale value
    o_wdata <= wr ? d : ~d;
    o_wr_n <= ~(i_sync_style & wr);
    repeat (3) @(posedge i_clk_sys);
    o_ale <= ale_hi;
    repeat (4) @(posedge i_clk_sys);
    // Scramble after hold time to prove latching
    if (!ale_hi) o_addr[7:0] <= ~a[7:0];
    repeat (2) @(posedge i_clk_sys);
    if (wr && !i_sync_style) o_wr_n <= 1'b0;
    else o_rd_n <= 1'b0;
    for (n = 0; n < 40 && i_done_n; n++) @(posedge i_clk_sys);
    ok = ~i_done_n;
    q = i_rdata;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    for (n = 0; n < 10 && !i_done_n; n++) @(posedge i_clk_sys);
    o_sel_n <= 1'b1;
    o_ale <= 1'b0;
    o_wdata <= ~o_wdata;
    busy_q <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_host_register_port.sv ----
// Purpose: Self-checking bench for the host register port.
// Assumes: Strap changes only while reset is held.
// Notes:   Read data is checked from a queue as it appears.
`default_nettype none
module tb_host_register_port
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, evt = 1'b0, done_p = 1'b1;
  logic [2:0] style = 3'h0;
  logic [7:0] status = 8'h00, d, st;
  logic sel_n, ale, rd_n, wr_n, hclk, oe_n, done_n, irq_n, bad;
  logic [10:0] addr;
  logic [7:0] wdata, rdata, cfg0;
  logic [7:0] exp_q[$];
  logic [2:0] styles[3] = '{STYLE_STROBE, STYLE_ALT, STYLE_SYNC};
  int miscompares = 0, comparisons = 0, seed = 64;

  always #12.5 clk = ~clk;

  host_register_port u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_bus_style_select(style),
    .i_sel_n(sel_n), .i_addr_latch_strobe(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_host_clk(hclk), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe_n(oe_n), .o_cycle_done_n(done_n), .i_status(status), .i_event(evt),
    .o_cfg0(cfg0), .o_irq_n(irq_n), .o_style_bad(bad));
  host_bus_model u_host (.i_clk_sys(clk), .i_sync_style(style == STYLE_SYNC),
    .i_done_n(done_n), .i_rdata(rdata), .o_sel_n(sel_n), .o_ale(ale), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_hclk(hclk), .o_addr(addr), .o_wdata(wdata));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic restyle(input logic [2:0] s);
    @(posedge clk);
    rst <= 1'b1;
    style <= s;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Two sync stages plus the registered flag
    repeat (4) @(posedge clk);
  endtask

  task automatic acc(input logic wr, input logic [10:0] a, input logic [7:0] v,
                     input logic ale_hi, input logic exp_ok);
    logic [7:0] q;
    logic ok;
    if (!wr && exp_ok) exp_q.push_back(v);
    u_host.xfer(wr, a, v, ale_hi, q, ok);
    chk("done", {7'h00, exp_ok}, {7'h00, ok});
  endtask

  // ****
  // Read data monitor
  // ****
  always @(negedge clk) begin
    if (!done_n && done_p && !oe_n) begin
      chk("rdata", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rdata);
    end
    done_p <= done_n;
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    restyle(STYLE_STROBE);
    chk("cfg0_rst", 8'h00, cfg0);
    chk("irq_rst", 8'h01, {7'h00, irq_n});
    foreach (styles[i]) begin
      restyle(styles[i]);
      d = 8'($random(seed));
      st = 8'($random(seed));
      status <= st;
      acc(1'b1, 11'h000, d, 1'b0, 1'b1);
      chk("cfg0", d, cfg0);
      acc(1'b0, 11'h000, d, 1'b0, 1'b1);
      acc(1'b1, 11'h7a5, ~d, 1'b1, 1'b1);
      acc(1'b0, 11'h0a5, ~d, 1'b0, 1'b1);
      acc(1'b1, 11'h0f3, ~st, 1'b1, 1'b1);
      acc(1'b0, 11'h0f3, st, 1'b1, 1'b1);
      acc(1'b1, 11'h2a5, d, 1'b1, 1'b0);
      acc(1'b0, 11'h0a5, ~d, 1'b1, 1'b1);
    end
    @(posedge clk);
    evt <= 1'b1;
    repeat (6) @(posedge clk);
    chk("irq", 8'h00, {7'h00, irq_n});
    restyle(3'h3);
    chk("bad", 8'h01, {7'h00, bad});
    acc(1'b1, 11'h000, 8'h3c, 1'b1, 1'b0);
    chk("cfg0_kept", 8'h00, cfg0);
    chk("rd_left", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule
`default_nettype wire
